// [hdl/timer16_byte_access_port.sv]
// Byte-wide register access path for a 16-bit timer/counter
// Operation
// - Count of zero flags bottom to counter
// - Count of all ones flags maximum always
// - Top from fixed values, compare A, capture
// - Each wide register is two byte locations
// - One shared high-byte shadow per timer
// - High-byte write goes only to shadow
// - Low-byte write loads shadow and byte together
// - Count or capture low-byte read copies upper byte to shadow
// - Compare reads bypass the shadow entirely
// - Shadow keeps its value after low write
// - Force bits in A, upper two mode bits in B
// - CPU counter write beats clear and count
// - Capture writable only in capture-top modes
`timescale 1ns/100ps
`include "timer16_consts.svh"
module timer16_byte_access_port (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [5:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic count_clear_i,
  input wire logic count_inc_i,
  input wire logic count_dec_i,
  input wire logic capture_stb_i,
  output logic [15:0] count_value_o,
  output logic [15:0] compare_reg_a_o,
  output logic [15:0] compare_reg_b_o,
  output logic [15:0] capture_reg_o,
  output logic [15:0] top_value_o,
  output logic [3:0] wave_mode_o,
  output logic [7:0] timer_control_a_o,
  output logic [7:0] timer_control_b_o,
  output logic force_compare_a_o,
  output logic force_compare_b_o,
  output logic at_bottom_o,
  output logic at_max_o,
  output logic at_top_o
);

  // Decode of the four mode bits into a top source
  function automatic timer16_pkg::top_src_t top_sel(input logic [3:0] m);
    case (m)
      4'h1, 4'h5: top_sel = timer16_pkg::TOP_FIX8;
      4'h2, 4'h6: top_sel = timer16_pkg::TOP_FIX9;
      4'h3, 4'h7: top_sel = timer16_pkg::TOP_FIX10;
      4'h4, 4'h9, 4'hB, 4'hF: top_sel = timer16_pkg::TOP_CMPA;
      4'h8, 4'hA, 4'hC, 4'hE: top_sel = timer16_pkg::TOP_CAP;
      default: top_sel = timer16_pkg::TOP_FULL;
    endcase
  endfunction

  logic ack_q; // Answer flag, one cycle
  logic [31:0] rdat_q; // Registered read data
  logic [7:0] shadow_q; // Shared high-byte shadow
  logic [7:0] ctrl_a_q; // Control A, force bits kept zero
  logic [7:0] ctrl_b_q; // Control B
  logic force_a_q; // Force pulse A
  logic force_b_q; // Force pulse B
  logic [15:0] count_q, count_d; // Counter value
  logic [15:0] cmpa_q; // Compare A
  logic [15:0] cmpb_q; // Compare B
  logic [15:0] cap_q, cap_d; // Capture register
  logic [15:0] top_q, top_d; // Active top value
  logic bottom_q, max_q, attop_q; // Count condition flags
  logic take, wr, rd; // Request decode
  logic [3:0] mode_d; // Mode bits after this edge
  timer16_pkg::top_src_t src_d, src_q; // Top source, next and now

  // Accept a request once per bus cycle
  assign take = cyc_i & stb_i & ~ack_q;
  assign wr = take & we_i & sel_i[0];
  assign rd = take & ~we_i;
  assign src_q = top_sel(wave_mode_o);

  // Acknowledge the cycle after a request; drop it next cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= take;
    end
  end

  // Read data mux, high locations of count and capture via shadow
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_q <= 32'h0000_0000;
    end else if (rd) begin
      rdat_q <= 32'h0000_0000;
      case (adr_i & 6'h3C)
        `OFS_CTRL_A: rdat_q[7:0] <= ctrl_a_q;
        `OFS_CTRL_B: rdat_q[7:0] <= ctrl_b_q;
        `OFS_CNT_LO: rdat_q[7:0] <= count_q[7:0];
        `OFS_CNT_HI: rdat_q[7:0] <= shadow_q;
        `OFS_CMPA_LO: rdat_q[7:0] <= cmpa_q[7:0];
        `OFS_CMPA_HI: rdat_q[7:0] <= cmpa_q[15:8];
        `OFS_CMPB_LO: rdat_q[7:0] <= cmpb_q[7:0];
        `OFS_CMPB_HI: rdat_q[7:0] <= cmpb_q[15:8];
        `OFS_CAP_LO: rdat_q[7:0] <= cap_q[7:0];
        `OFS_CAP_HI: rdat_q[7:0] <= shadow_q;
        `OFS_STATUS: rdat_q[2:0] <= {attop_q, max_q, bottom_q};
        default: rdat_q <= 32'h0000_0000; // Unmapped reads zero
      endcase
    end
  end

  // Shared shadow: loaded by high writes and count or capture low reads only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shadow_q <= 8'h00;
    end else if (wr) begin
      case (adr_i & 6'h3C)
        `OFS_CNT_HI, `OFS_CMPA_HI, `OFS_CMPB_HI, `OFS_CAP_HI:
          shadow_q <= dat_i[7:0];
        default: shadow_q <= shadow_q; // Low writes keep it
      endcase
    end else if (rd) begin
      case (adr_i & 6'h3C)
        `OFS_CNT_LO: shadow_q <= count_q[15:8];
        `OFS_CAP_LO: shadow_q <= cap_q[15:8];
        default: shadow_q <= shadow_q; // Compare reads bypass
      endcase
    end
  end

  // Control registers; force bits become one-cycle strobes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_a_q <= `CTRL_RST;
      ctrl_b_q <= `CTRL_RST;
      force_a_q <= 1'b0;
      force_b_q <= 1'b0;
    end else begin
      force_a_q <= 1'b0;
      force_b_q <= 1'b0;
      if (wr && (adr_i & 6'h3C) == `OFS_CTRL_A) begin
        ctrl_a_q <= dat_i[7:0] & ~8'h0C;
        force_a_q <= dat_i[`CA_FORCE_A];
        force_b_q <= dat_i[`CA_FORCE_B];
      end
      if (wr && (adr_i & 6'h3C) == `OFS_CTRL_B) begin
        ctrl_b_q <= dat_i[7:0];
      end
    end
  end

  // Mode bits as they stand after this edge
  always_comb begin
    mode_d = {ctrl_b_q[`CB_WAVE3], ctrl_b_q[`CB_WAVE2],
              ctrl_a_q[`CA_WAVE1], ctrl_a_q[`CA_WAVE0]};
    if (wr && (adr_i & 6'h3C) == `OFS_CTRL_A) begin
      mode_d[1:0] = {dat_i[`CA_WAVE1], dat_i[`CA_WAVE0]};
    end
    if (wr && (adr_i & 6'h3C) == `OFS_CTRL_B) begin
      mode_d[3:2] = {dat_i[`CB_WAVE3], dat_i[`CB_WAVE2]};
    end
  end

  // Next counter value; a CPU write wins over counting
  always_comb begin
    if (wr && (adr_i & 6'h3C) == `OFS_CNT_LO) begin
      count_d = {shadow_q, dat_i[7:0]};
    end else if (count_clear_i) begin
      count_d = `CNT_BOTTOM;
    end else if (count_inc_i) begin
      count_d = count_q + 16'h0001;
    end else if (count_dec_i) begin
      count_d = count_q - 16'h0001;
    end else begin
      count_d = count_q;
    end
  end

  // Next capture value; CPU write only with capture as top
  always_comb begin
    cap_d = cap_q;
    if (top_sel(wave_mode_o) == timer16_pkg::TOP_CAP) begin
      if (wr && (adr_i & 6'h3C) == `OFS_CAP_LO) begin
        cap_d = {shadow_q, dat_i[7:0]};
      end
    end else if (capture_stb_i) begin
      cap_d = count_q; // Time stamp of an event
    end
  end

  // Counter and capture registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_q <= `WIDE_RST;
      cap_q <= `WIDE_RST;
    end else begin
      count_q <= count_d;
      cap_q <= cap_d;
    end
  end

  // Compare registers, loaded whole on low-byte writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmpa_q <= `WIDE_RST;
      cmpb_q <= `WIDE_RST;
    end else if (wr) begin
      if ((adr_i & 6'h3C) == `OFS_CMPA_LO) begin
        cmpa_q <= {shadow_q, dat_i[7:0]};
      end
      if ((adr_i & 6'h3C) == `OFS_CMPB_LO) begin
        cmpb_q <= {shadow_q, dat_i[7:0]};
      end
    end
  end

  // Top value from the mode selected after this edge
  always_comb begin
    src_d = top_sel(mode_d);
    case (src_d)
      timer16_pkg::TOP_FIX8: top_d = `TOP_8BIT;
      timer16_pkg::TOP_FIX9: top_d = `TOP_9BIT;
      timer16_pkg::TOP_FIX10: top_d = `TOP_10BIT;
      timer16_pkg::TOP_CMPA: top_d = (wr && (adr_i & 6'h3C) ==
        `OFS_CMPA_LO) ? {shadow_q, dat_i[7:0]} : cmpa_q;
      timer16_pkg::TOP_CAP: top_d = cap_d;
      default: top_d = `CNT_MAX;
    endcase
  end

  // Count conditions, registered together with the count
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      top_q <= `CNT_MAX;
      bottom_q <= 1'b1;
      max_q <= 1'b0;
      attop_q <= 1'b0;
    end else begin
      top_q <= top_d;
      bottom_q <= (count_d == `CNT_BOTTOM);
      max_q <= (count_d == `CNT_MAX);
      attop_q <= (count_d == top_d);
    end
  end

  // Outputs straight from flip-flops
  assign dat_o = rdat_q;
  assign ack_o = ack_q;
  assign count_value_o = count_q;
  assign compare_reg_a_o = cmpa_q;
  assign compare_reg_b_o = cmpb_q;
  assign capture_reg_o = cap_q;
  assign top_value_o = top_q;
  assign wave_mode_o = {ctrl_b_q[`CB_WAVE3], ctrl_b_q[`CB_WAVE2],
                        ctrl_a_q[`CA_WAVE1], ctrl_a_q[`CA_WAVE0]};
  assign timer_control_a_o = ctrl_a_q;
  assign timer_control_b_o = ctrl_b_q;
  assign force_compare_a_o = force_a_q;
  assign force_compare_b_o = force_b_q;
  assign at_bottom_o = bottom_q;
  assign at_max_o = max_q;
  assign at_top_o = attop_q;

  // Checks on the byte access path
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_bottom;
    at_bottom_o == (count_value_o == 16'h0000);
  endproperty
  a_bottom: assert property (p_bottom)
    else $error("bottom flag does not match count");

  property p_max;
    at_max_o == (count_value_o == 16'hFFFF);
  endproperty
  a_max: assert property (p_max)
    else $error("max flag does not match count");

  property p_top_fixed;
    (wave_mode_o == 4'h2) |-> top_value_o == 16'h01FF;
  endproperty
  a_top_fixed: assert property (p_top_fixed)
    else $error("fixed top wrong in mode 2");

  property p_top_cmpa;
    (wave_mode_o == 4'hF) |-> top_value_o == compare_reg_a_o;
  endproperty
  a_top_cmpa: assert property (p_top_cmpa)
    else $error("top does not follow compare A");

  property p_ack_once;
    ack_o |=> !ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once)
    else $error("ack stands more than one cycle");

  property p_hi_write;
    (wr && (adr_i & 6'h3C) == `OFS_CMPB_HI) |=>
      $stable(compare_reg_b_o) && shadow_q == $past(dat_i[7:0]);
  endproperty
  a_hi_write: assert property (p_hi_write)
    else $error("high write reached compare B");

  property p_lo_write;
    (wr && (adr_i & 6'h3C) == `OFS_CMPA_LO) |=>
      compare_reg_a_o == {$past(shadow_q), $past(dat_i[7:0])}
      && $stable(shadow_q);
  endproperty
  a_lo_write: assert property (p_lo_write)
    else $error("low write did not load whole register");

  property p_lo_read;
    (rd && (adr_i & 6'h3C) == `OFS_CNT_LO) |=>
      shadow_q == $past(count_value_o[15:8]);
  endproperty
  a_lo_read: assert property (p_lo_read)
    else $error("low read did not fill shadow");

  property p_cmp_read;
    (rd && (adr_i & 6'h3C) == `OFS_CMPA_HI) |=>
      dat_o[7:0] == $past(compare_reg_a_o[15:8]) && $stable(shadow_q);
  endproperty
  a_cmp_read: assert property (p_cmp_read)
    else $error("compare high read used shadow");

  property p_force;
    (wr && (adr_i & 6'h3C) == `OFS_CTRL_A && dat_i[3]) |=>
      force_compare_a_o ##1 !force_compare_a_o;
  endproperty
  a_force: assert property (p_force)
    else $error("force strobe not one cycle");

  property p_cnt_prio;
    (wr && (adr_i & 6'h3C) == `OFS_CNT_LO && count_inc_i) |=>
      count_value_o == {$past(shadow_q), $past(dat_i[7:0])};
  endproperty
  a_cnt_prio: assert property (p_cnt_prio)
    else $error("count beat a CPU write");

  property p_cap_lock;
    (wr && (adr_i & 6'h3C) == `OFS_CAP_LO && src_q != timer16_pkg::TOP_CAP
     && !capture_stb_i) |=> $stable(capture_reg_o);
  endproperty
  a_cap_lock: assert property (p_cap_lock)
    else $error("capture written outside capture-top mode");

  c_wide_write: cover property (wr && (adr_i & 6'h3C) == `OFS_CNT_HI
    ##[1:20] wr && (adr_i & 6'h3C) == `OFS_CNT_LO);
  c_wide_read: cover property (rd && (adr_i & 6'h3C) == `OFS_CAP_LO
    ##[1:20] rd && (adr_i & 6'h3C) == `OFS_CAP_HI);
  c_wrap: cover property (at_max_o ##1 at_bottom_o);

endmodule

// [hdl/timer16_consts.svh]
// Offsets, field positions, reset values and fixed count limits
`ifndef TIMER16_CONSTS_SVH
`define TIMER16_CONSTS_SVH
// Word offsets on the register bus
`define OFS_CTRL_A 6'h00
`define OFS_CTRL_B 6'h04
`define OFS_CNT_LO 6'h08
`define OFS_CNT_HI 6'h0C
`define OFS_CMPA_LO 6'h10
`define OFS_CMPA_HI 6'h14
`define OFS_CMPB_LO 6'h18
`define OFS_CMPB_HI 6'h1C
`define OFS_CAP_LO 6'h20
`define OFS_CAP_HI 6'h24
`define OFS_STATUS 6'h28
// Control A fields
`define CA_WAVE0 0
`define CA_WAVE1 1
`define CA_FORCE_B 2
`define CA_FORCE_A 3
// Control B fields
`define CB_WAVE2 3
`define CB_WAVE3 4
// Reset values
`define CTRL_RST 8'h00
`define WIDE_RST 16'h0000
// Count limits
`define CNT_BOTTOM 16'h0000
`define CNT_MAX 16'hFFFF
`define TOP_8BIT 16'h00FF
`define TOP_9BIT 16'h01FF
`define TOP_10BIT 16'h03FF
`endif

// [hdl/timer16_pkg.sv]
// Types shared by the timer byte access port
package timer16_pkg;
  // Source of the top of the count sequence
  typedef enum logic [5:0] {
    TOP_FULL = 6'h01,
    TOP_FIX8 = 6'h02,
    TOP_FIX9 = 6'h04,
    TOP_FIX10 = 6'h08,
    TOP_CMPA = 6'h10,
    TOP_CAP = 6'h20
  } top_src_t;
endpackage

// [sim/cpu_bus_model.sv]
// CPU side model: byte-wide classic bus master for the timer port
`timescale 1ns/100ps
module cpu_bus_model (
  input wire logic clk_i, // System clock
  input wire logic ack_i, // Slave acknowledge
  input wire logic [31:0] dat_i, // Read data
  output logic cyc_o, // Cycle
  output logic stb_o, // Strobe
  output logic we_o, // Write enable
  output logic [5:0] adr_o, // Byte address
  output logic [3:0] sel_o, // Byte enables
  output logic [31:0] dat_o // Write data
);
  // Idle bus at time zero
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 6'h3F;
    sel_o = 4'h0;
    dat_o = 32'h0;
  end
  // One whole byte cycle, never interleaved with another
  task automatic xfer(input logic w, input logic [5:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    sel_o <= 4'h1;
    dat_o <= {24'h0, d};
    @(posedge clk_i);
    // Hold request until ack is sampled high
    while (ack_i !== 1'b1) begin
      @(posedge clk_i);
    end
    q = dat_i[7:0];
    // Release; stale lines show inverted values
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    sel_o <= 4'h0;
    we_o <= ~w;
    adr_o <= ~a;
    dat_o <= ~{24'h0, d};
  endtask
  // Byte write
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] q;
    xfer(1'b1, a, d, q);
  endtask
  // Byte read
  task automatic rd(input logic [5:0] a, output logic [7:0] q);
    xfer(1'b0, a, 8'h00, q);
  endtask
endmodule

// [sim/timer16_byte_access_port_tb_top.sv]
// Self-checking testbench for the timer byte access port
`timescale 1ns/100ps
`include "timer16_consts.svh"
module timer16_byte_access_port_tb_top;
  logic clk_i = 1'b0; // System clock
  logic rst_i = 1'b1; // Reset, high at start
  logic cyc, stb, we, ack; // Bus handshake
  logic [5:0] adr; // Byte address
  logic [3:0] sel; // Byte enables
  logic [31:0] wdat, rdat; // Bus data
  logic clr = 1'b0; // Counter clear command
  logic inc = 1'b0; // Counter increment command
  logic dec = 1'b0; // Counter decrement command
  logic cap_stb = 1'b0; // Capture strobe
  logic [15:0] cnt, cmpa, cmpb, capv, top; // Wide register views
  logic [3:0] mode; // Mode bits
  logic [7:0] ca, cb, b; // Control bytes, read byte
  logic fa, fb, bot, mx, tp; // Pulses and flags
  int n_mismatch = 0; // Mismatches
  int n_checks = 0; // Comparisons
  int cycles = 0; // Timeout counter
  int nfa = 0; // Force A pulses seen
  int nfb = 0; // Force B pulses seen
  timer16_byte_access_port uut (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
    .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .count_clear_i(clr),
    .count_inc_i(inc), .count_dec_i(dec), .capture_stb_i(cap_stb),
    .count_value_o(cnt), .compare_reg_a_o(cmpa),
    .compare_reg_b_o(cmpb), .capture_reg_o(capv), .top_value_o(top),
    .wave_mode_o(mode), .timer_control_a_o(ca), .timer_control_b_o(cb),
    .force_compare_a_o(fa), .force_compare_b_o(fb), .at_bottom_o(bot),
    .at_max_o(mx), .at_top_o(tp));
  cpu_bus_model cpu (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat),
    .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel),
    .dat_o(wdat));
  // Clock
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  // Force pulse counters and hang guard
  always @(posedge clk_i) begin
    if (fa === 1'b1) nfa <= nfa + 1;
    if (fb === 1'b1) nfb <= nfb + 1;
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_mismatch++;
      test_done();
    end
  end
  // Compare one value
  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  // Wide write, high byte first
  task automatic ww(input logic [5:0] lo, input logic [15:0] v);
    cpu.wr(lo + 6'h04, v[15:8]);
    cpu.wr(lo, v[7:0]);
  endtask
  // Set the four mode bits
  task automatic setmode(input logic [3:0] m);
    cpu.wr(`OFS_CTRL_A, {6'h00, m[1:0]});
    cpu.wr(`OFS_CTRL_B, {3'h0, m[3:2], 3'h0});
  endtask
  // Expected top for a mode
  function automatic logic [15:0] exp_top(input int m, logic [15:0] c);
    case (m)
      1, 5: exp_top = `TOP_8BIT;
      2, 6: exp_top = `TOP_9BIT;
      3, 7: exp_top = `TOP_10BIT;
      4, 9, 11, 15: exp_top = 16'hAB12;
      8, 10, 12, 14: exp_top = c;
      default: exp_top = `CNT_MAX;
    endcase
  endfunction
  // Reset state
  task automatic t_reset;
    chk("count", 16'h0000, cnt);
    chk("bottom", 16'h0001, {15'h0, bot});
    chk("top", 16'hFFFF, top);
    $display("t_reset done");
  endtask
  // Counter write and read through shadow
  task automatic t_count;
    cpu.wr(`OFS_CNT_HI, 8'h01);
    chk("count", 16'h0000, cnt);
    cpu.wr(`OFS_CNT_LO, 8'hFF);
    chk("count", 16'h01FF, cnt);
    chk("bottom", 16'h0000, {15'h0, bot});
    cpu.rd(`OFS_CNT_LO, b);
    chk("low", 16'h00FF, {8'h0, b});
    @(posedge clk_i);
    inc <= 1'b1;
    @(posedge clk_i);
    inc <= 1'b0;
    @(posedge clk_i);
    chk("count", 16'h0200, cnt);
    cpu.rd(`OFS_CNT_HI, b);
    chk("high", 16'h0001, {8'h0, b});
    $display("t_count done");
  endtask
  // Shared shadow, reuse and compare bypass
  task automatic t_reuse;
    cpu.wr(`OFS_CMPA_HI, 8'hAB);
    cpu.wr(`OFS_CMPA_LO, 8'h12);
    cpu.wr(`OFS_CMPB_LO, 8'h34);
    chk("cmpa", 16'hAB12, cmpa);
    chk("cmpb", 16'hAB34, cmpb);
    cpu.rd(`OFS_CNT_LO, b);
    cpu.rd(`OFS_CMPA_HI, b);
    chk("cmpa high", 16'h00AB, {8'h0, b});
    cpu.rd(`OFS_CMPB_LO, b);
    cpu.rd(`OFS_CNT_HI, b);
    chk("count high", 16'h0002, {8'h0, b});
    cpu.wr(`OFS_CMPB_HI, 8'h5A);
    cpu.rd(`OFS_CNT_HI, b);
    chk("shared", 16'h005A, {8'h0, b});
    $display("t_reuse done");
  endtask
  // CPU write against clear and increment in the same cycle
  task automatic t_prio;
    cpu.wr(`OFS_CNT_HI, 8'h12);
    fork
      cpu.wr(`OFS_CNT_LO, 8'h34);
      begin
        @(posedge clk_i);
        clr <= 1'b1;
        inc <= 1'b1;
        @(posedge clk_i);
        clr <= 1'b0;
        inc <= 1'b0;
      end
    join
    chk("count", 16'h1234, cnt);
    $display("t_prio done");
  endtask
  // Modes, top, max, capture, force, status, unmapped
  task automatic t_modes;
    ww(`OFS_CNT_LO, 16'hFFFF);
    chk("max", 16'h0001, {15'h0, mx});
    for (int m = 0; m < 16; m++) begin
      setmode(m[3:0]);
      chk("mode", m[15:0], {12'h0, mode});
      chk("top", exp_top(m, 16'h0000), top);
    end
    setmode(4'h0);
    ww(`OFS_CAP_LO, 16'h0123);
    chk("capture", 16'h0000, capv);
    setmode(4'h8);
    ww(`OFS_CAP_LO, 16'h0123);
    chk("capture", 16'h0123, capv);
    chk("top", 16'h0123, top);
    setmode(4'h0);
    cpu.rd(`OFS_STATUS, b);
    chk("status", 16'h0006, {8'h0, b});
    cpu.wr(`OFS_CTRL_A, 8'h0C);
    @(posedge clk_i);
    chk("force a", 16'h0001, nfa[15:0]);
    chk("force b", 16'h0001, nfb[15:0]);
    cpu.rd(`OFS_CTRL_A, b);
    chk("ctrl a", 16'h0000, {8'h0, b});
    cpu.rd(6'h3C, b);
    chk("unmapped", 16'h0000, {8'h0, b});
    $display("t_modes done");
  endtask
  // Decrement, capture strobe, control B and top flag
  task automatic t_events;
    cpu.wr(`OFS_CTRL_B, 8'hE7);
    chk("ctrl b", 16'h00E7, {8'h0, cb});
    chk("mode", 16'h0000, {12'h0, mode});
    chk("at top", 16'h0001, {15'h0, tp});
    @(posedge clk_i);
    dec <= 1'b1;
    @(posedge clk_i);
    dec <= 1'b0;
    @(posedge clk_i);
    chk("count", 16'hFFFE, cnt);
    chk("max", 16'h0000, {15'h0, mx});
    cap_stb <= 1'b1;
    @(posedge clk_i);
    cap_stb <= 1'b0;
    @(posedge clk_i);
    chk("capture", 16'hFFFE, capv);
    cpu.rd(`OFS_CAP_LO, b);
    chk("cap low", 16'h00FE, {8'h0, b});
    cpu.rd(`OFS_CAP_HI, b);
    chk("cap high", 16'h00FF, {8'h0, b});
    $display("t_events done");
  endtask
  // Verdict and end of run
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_count();
    t_reuse();
    t_prio();
    t_modes();
    t_events();
    test_done();
  end
endmodule
